// ==== testbench/pifm_field.sv ====
// Field contact model that drives the five digital input pins.
`timescale 1ns/1ps
module pifm_field (
	input wire logic [4:0] off_mask,
	output logic [4:0] di
);
	// Normally closed contacts read on unless the bench opens them on purpose.
	assign di = ~off_mask;
endmodule : pifm_field

// ==== testbench/pifm_properties.sv ====
// Concurrent checks on the ports of the I/O function map.
`timescale 1ns/1ps
module pifm_checker (
	input wire logic CLK,
	input wire logic RST,
	input wire logic [7:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [15:0] RDATA,
	input wire logic CONTROL_POWER_OK,
	input wire logic CTRL_CIRCUIT_FAULT,
	input wire logic MOTOR_POWER_FAULT,
	input wire logic FAULT_FLAG,
	input wire logic DRIVE_READY
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	sequence sel_write; WR && ADDR == 8'h00; endsequence
	sequence sel_read; RD && ADDR == 8'h00; endsequence
	ready_cause_a: assert property (
		DRIVE_READY |-> $past(CONTROL_POWER_OK) && !$past(CTRL_CIRCUIT_FAULT)
		&& !$past(MOTOR_POWER_FAULT)) else $error("ready without clean supply");
	fault_excl_a: assert property (
		FAULT_FLAG |-> !DRIVE_READY) else $error("ready during alarm");
	ctrl_fault_a: assert property (
		CONTROL_POWER_OK && CTRL_CIRCUIT_FAULT |=> FAULT_FLAG && !DRIVE_READY)
		else $error("control fault missed");
	motor_fault_a: assert property (
		CONTROL_POWER_OK && MOTOR_POWER_FAULT |=> FAULT_FLAG && !DRIVE_READY)
		else $error("motor fault missed");
	power_off_a: assert property (
		!CONTROL_POWER_OK |=> !DRIVE_READY && !FAULT_FLAG) else $error("output without power");
	ready_or_fault_a: assert property (
		CONTROL_POWER_OK && !CTRL_CIRCUIT_FAULT && !MOTOR_POWER_FAULT
		|=> DRIVE_READY || FAULT_FLAG) else $error("neither ready nor fault");
	sel_readback_a: assert property (
		sel_write ##1 !WR ##1 sel_read |=> RDATA == {8'h00, $past(WDATA[7:0], 3)})
		else $error("select readback wrong");
	rd_idle_a: assert property (
		!RD |=> RDATA == 16'h0000) else $error("read data outside read");
endmodule : pifm_checker
bind pifm_top pifm_checker u_chk (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
	.RD(RD), .RDATA(RDATA), .CONTROL_POWER_OK(CONTROL_POWER_OK),
	.CTRL_CIRCUIT_FAULT(CTRL_CIRCUIT_FAULT), .MOTOR_POWER_FAULT(MOTOR_POWER_FAULT),
	.FAULT_FLAG(FAULT_FLAG), .DRIVE_READY(DRIVE_READY));

// ==== testbench/pifm_test.sv ====
// Self-checking bench of the I/O function map.
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin n_errors++; \
	$display("CHECK FAILED %s exp %h saw %h", n, e, s); end end
module programmable_io_function_map_test;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic rd_d = 1'b0;
	logic pwr = 1'b1;
	logic ctrl_f = 1'b0;
	logic motor_f = 1'b0;
	logic [15:0] speed = 16'h0100;
	logic [15:0] spd;
	logic [15:0] thr;
	logic zs;
	logic [4:0] off = 5'h01;
	logic [4:0] di;
	logic [15:0] rdata;
	logic [15:0] exp_q[$];
	logic [15:0] exp_v;
	logic [3:0] exp_p[$];
	logic [3:0] ep;
	logic [1:0] dol;
	logic flt;
	logic rdy;
	logic pin_req = 1'b0;
	logic [15:0] rv [8] = '{16'h0000, 16'h0000, 16'h0022, 16'h0023, 16'h0021, 16'h0001,
		16'h0003, 16'h000A};
	int pin [3] = '{4, 2, 3};
	int n_errors = 0;
	int check_count = 0;

	pifm_top uut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .DI_LEVEL(di), .DO_LEVEL(dol), .CONTROL_POWER_OK(pwr),
		.CTRL_CIRCUIT_FAULT(ctrl_f), .MOTOR_POWER_FAULT(motor_f), .MOTOR_SPEED(speed),
		.FAULT_FLAG(flt), .DRIVE_READY(rdy));
	pifm_field u_field (.off_mask(off), .di(di));

	initial begin
		forever #12.5 clk = ~clk;
	end

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask : idle

	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask : rd_reg

	// Notes the expected {output 2, output 1, fault, ready} pin levels for the monitor.
	task automatic chk_pins(input logic [3:0] e);
		@(posedge clk);
		exp_p.push_back(e);
		pin_req <= 1'b1;
		@(posedge clk);
		pin_req <= 1'b0;
	endtask : chk_pins

	// The clear contact sits on input 1 and is pulled low between pulses.
	task automatic pulse_clear();
		off[0] <= 1'b0;
		idle(3);
		off[0] <= 1'b1;
		idle(3);
	endtask : pulse_clear

	task automatic end_sim();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim

	always @(posedge clk) begin
		rd_d <= rd;
		if (rd_d) begin
			exp_v = exp_q.pop_front();
			`CHK("read data", exp_v, rdata)
		end
		if (pin_req) begin
			ep = exp_p.pop_front();
			`CHK("pin levels", ep, {dol, flt, rdy})
		end
	end

	initial begin
		idle(5000);
		n_errors++;
		end_sim();
	end

	initial begin
		void'($urandom(32'h9e8406ef));
		idle(8);
		rst <= 1'b0;
		idle(2);
		for (int i = 0; i < 8; i++) rd_reg(i[7:0], rv[i]);
		rd_reg(8'h08, 16'h0005);
		chk_pins(4'h5);
		rd_reg(8'h20, 16'h0000);
		wr_reg(8'h08, 16'hFFFF);
		rd_reg(8'h08, 16'h0005);
		for (int i = 0; i < 5; i++) begin
			case (i)
				0, 1, 2: off[pin[i]] <= 1'b1;
				3: ctrl_f <= 1'b1;
				default: motor_f <= 1'b1;
			endcase
			idle(3);
			off <= 5'h01;
			ctrl_f <= 1'b0;
			motor_f <= 1'b0;
			idle(2);
			rd_reg(8'h08, 16'h0006);
			rd_reg(8'h09, 16'h0001 << i);
			chk_pins(4'h2);
			if (i == 0) begin
				pulse_clear();
				rd_reg(8'h08, 16'h0006);
				wr_reg(8'h00, 16'hFF02);
				rd_reg(8'h00, 16'h0002);
			end
			pulse_clear();
			rd_reg(8'h08, 16'h0005);
			rd_reg(8'h09, 16'h0000);
			chk_pins(4'h5);
		end
		pwr <= 1'b0;
		idle(2);
		rd_reg(8'h08, 16'h0000);
		chk_pins(4'h0);
		pwr <= 1'b1;
		idle(2);
		rd_reg(8'h08, 16'h0005);
		for (int i = 0; i < 8; i++) begin
			thr = 16'($urandom) & 16'h01FF;
			spd = (i == 0) ? thr : 16'($urandom) & 16'h01FF;
			zs = spd < thr;
			speed <= spd;
			wr_reg(8'h07, thr);
			rd_reg(8'h07, thr);
			rd_reg(8'h08, {12'h000, zs, 3'h5});
			rd_reg(8'h0A, {6'h00, zs, 1'b1, 3'h0, 5'h1E});
			chk_pins({zs, 3'h5});
		end
		wr_reg(8'h05, 16'h0003);
		wr_reg(8'h06, 16'h0055);
		rd_reg(8'h0A, {6'h00, 1'b0, zs, 3'h0, 5'h1E});
		chk_pins({1'b0, zs, 2'h1});
		idle(3);
		rst <= 1'b1;
		idle(2);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++) rd_reg(i[7:0], rv[i]);
		chk_pins({spd < 16'h000A, 3'h5});
		idle(3);
		end_sim();
	end
endmodule : programmable_io_function_map_test

// ==== verilog/pifm_in_decode.sv ====
// Decodes the input pin selects into per-function activity.
`timescale 1ns/1ps
`include "pifm_regs.svh"

module pifm_in_decode #(
	parameter int NUM_IN = 5
) (
	input wire logic [NUM_IN-1:0] pin_level,
	input wire pifm_pkg::pifm_code_type sel [NUM_IN],
	output logic clear_on,
	output logic halt_off,
	output logic rev_off,
	output logic fwd_off
);
	import pifm_pkg::*;

	logic [NUM_IN-1:0] clr_hit;
	logic [NUM_IN-1:0] halt_hit;
	logic [NUM_IN-1:0] rev_hit;
	logic [NUM_IN-1:0] fwd_hit;

	// A function on no pin yields no hit, so it stays inactive.
	genvar i;
	generate
		for (i = 0; i < NUM_IN; i++) begin : g_pin
			assign clr_hit[i] = (sel[i] == `PIFM_CODE_CLEAR) && pin_level[i];
			assign halt_hit[i] = (sel[i] == `PIFM_CODE_HALT) && !pin_level[i];
			assign rev_hit[i] = (sel[i] == `PIFM_CODE_REV) && !pin_level[i];
			assign fwd_hit[i] = (sel[i] == `PIFM_CODE_FWD) && !pin_level[i];
		end
	endgenerate

	assign clear_on = |clr_hit;
	assign halt_off = |halt_hit;
	assign rev_off = |rev_hit;
	assign fwd_off = |fwd_hit;

endmodule : pifm_in_decode

// ==== verilog/pifm_out_select.sv ====
// Picks the function that one output pin carries.
`timescale 1ns/1ps
`include "pifm_regs.svh"

module pifm_out_select (
	input wire pifm_pkg::pifm_code_type sel,
	input wire logic ready,
	input wire logic zero_speed,
	output logic level
);
	import pifm_pkg::*;

	always_comb begin
		case (sel)
			`PIFM_CODE_READY: level = ready;
			`PIFM_CODE_ZSPEED: level = zero_speed;
			default: level = 1'b0;
		endcase
	end

endmodule : pifm_out_select

// ==== verilog/pifm_pkg.sv ====
// Types shared by the I/O function map modules.
package pifm_pkg;

	typedef logic [7:0] pifm_code_type;

	typedef enum logic [1:0] {
		PIFM_NOPOWER = 2'b00,
		PIFM_READY = 2'b01,
		PIFM_FAULT = 2'b11
	} pifm_state_type;

endpackage : pifm_pkg

// ==== verilog/pifm_regs.svh ====
// Register offsets, field positions, reset values and function codes of the I/O function map.
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
`ifndef PIFM_REGS_SVH
`define PIFM_REGS_SVH

`define PIFM_ADDR_IN1_SEL 8'h00
`define PIFM_ADDR_IN2_SEL 8'h01
`define PIFM_ADDR_IN3_SEL 8'h02
`define PIFM_ADDR_IN4_SEL 8'h03
`define PIFM_ADDR_IN5_SEL 8'h04
`define PIFM_ADDR_OUT1_SEL 8'h05
`define PIFM_ADDR_OUT2_SEL 8'h06
`define PIFM_ADDR_ZS_THRESH 8'h07
`define PIFM_ADDR_STATUS 8'h08
`define PIFM_ADDR_CAUSE 8'h09
`define PIFM_ADDR_PINS 8'h0A

`define PIFM_CODE_NONE 8'h00
`define PIFM_CODE_READY 8'h01
`define PIFM_CODE_CLEAR 8'h02
`define PIFM_CODE_ZSPEED 8'h03
`define PIFM_CODE_HALT 8'h21
`define PIFM_CODE_REV 8'h22
`define PIFM_CODE_FWD 8'h23

`define PIFM_RST_IN1_SEL 8'h00
`define PIFM_RST_IN2_SEL 8'h00
`define PIFM_RST_IN3_SEL 8'h22
`define PIFM_RST_IN4_SEL 8'h23
`define PIFM_RST_IN5_SEL 8'h21
`define PIFM_RST_OUT1_SEL 8'h01
`define PIFM_RST_OUT2_SEL 8'h03
`define PIFM_RST_ZS_THRESH 16'h000A

`define PIFM_ST_READY 0
`define PIFM_ST_FAULT 1
`define PIFM_ST_POWER 2
`define PIFM_ST_ZSPEED 3

`define PIFM_CAUSE_HALT 0
`define PIFM_CAUSE_REV 1
`define PIFM_CAUSE_FWD 2
`define PIFM_CAUSE_CTRL 3
`define PIFM_CAUSE_MOTOR 4

`endif

// ==== verilog/pifm_top.sv ====
// Programmable digital I/O function map with alarm latch and register port.
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "pifm_regs.svh"

module pifm_top #(
	parameter int NUM_IN = 5,
	parameter int NUM_OUT = 2,
	parameter int SPEED_W = 16
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic [7:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [15:0] RDATA,
	input wire logic [NUM_IN-1:0] DI_LEVEL,
	output logic [NUM_OUT-1:0] DO_LEVEL,
	input wire logic CONTROL_POWER_OK,
	input wire logic CTRL_CIRCUIT_FAULT,
	input wire logic MOTOR_POWER_FAULT,
	input wire logic [SPEED_W-1:0] MOTOR_SPEED,
	output logic FAULT_FLAG,
	output logic DRIVE_READY
);
	import pifm_pkg::*;

	//--------------------------------------------------------------------------
	// Parameter checks
	//--------------------------------------------------------------------------
	// The select decode and the pin word are laid out for five inputs and two outputs.
	generate
		if (NUM_IN != 5) begin : g_bad_in
			$error("pifm_top serves exactly five digital inputs.");
		end
		if (NUM_OUT != 2) begin : g_bad_out
			$error("pifm_top serves exactly two digital outputs.");
		end
		if (SPEED_W < 1 || SPEED_W > 16) begin : g_bad_speed
			$error("pifm_top serves a speed word of 1 to 16 bits.");
		end
		if ((`PIFM_RST_ZS_THRESH >> SPEED_W) != 0) begin : g_bad_thresh
			$error("pifm_top cannot hold the reset zero speed threshold in SPEED_W bits.");
		end
	endgenerate

	//--------------------------------------------------------------------------
	// Constant checks
	//--------------------------------------------------------------------------
	// An unassigned pin holds the empty code, so no function code may equal it.
	generate
		if (`PIFM_CODE_READY == `PIFM_CODE_NONE || `PIFM_CODE_ZSPEED == `PIFM_CODE_NONE
			|| `PIFM_CODE_CLEAR == `PIFM_CODE_NONE || `PIFM_CODE_HALT == `PIFM_CODE_NONE
			|| `PIFM_CODE_REV == `PIFM_CODE_NONE
			|| `PIFM_CODE_FWD == `PIFM_CODE_NONE) begin : g_bad_none
			$error("pifm_top needs every function code to differ from the empty code.");
		end
		if (`PIFM_CODE_READY == `PIFM_CODE_ZSPEED) begin : g_bad_out_code
			$error("pifm_top needs two distinct output function codes.");
		end
		if (`PIFM_CODE_CLEAR == `PIFM_CODE_HALT || `PIFM_CODE_CLEAR == `PIFM_CODE_REV
			|| `PIFM_CODE_CLEAR == `PIFM_CODE_FWD || `PIFM_CODE_HALT == `PIFM_CODE_REV
			|| `PIFM_CODE_HALT == `PIFM_CODE_FWD
			|| `PIFM_CODE_REV == `PIFM_CODE_FWD) begin : g_bad_in_code
			$error("pifm_top needs four distinct input function codes.");
		end
		if (`PIFM_CAUSE_HALT > 4 || `PIFM_CAUSE_REV > 4 || `PIFM_CAUSE_FWD > 4
			|| `PIFM_CAUSE_CTRL > 4 || `PIFM_CAUSE_MOTOR > 4) begin : g_bad_cause
			$error("pifm_top keeps its alarm causes in a five bit word.");
		end
		if (`PIFM_ST_READY > 15 || `PIFM_ST_FAULT > 15 || `PIFM_ST_POWER > 15
			|| `PIFM_ST_ZSPEED > 15) begin : g_bad_status
			$error("pifm_top keeps its status bits in a sixteen bit word.");
		end
	endgenerate

	//--------------------------------------------------------------------------
	// Configuration registers
	//--------------------------------------------------------------------------
	pifm_code_type in_sel_q [NUM_IN];
	pifm_code_type in_sel_d [NUM_IN];
	pifm_code_type out_sel_q [NUM_OUT];
	pifm_code_type out_sel_d [NUM_OUT];
	logic [SPEED_W-1:0] thresh_q;
	logic [SPEED_W-1:0] thresh_d;

	always_comb begin
		in_sel_d = in_sel_q;
		out_sel_d = out_sel_q;
		thresh_d = thresh_q;
		if (WR) begin
			if (ADDR == `PIFM_ADDR_IN1_SEL) begin
				in_sel_d[0] = WDATA[7:0];
			end else if (ADDR == `PIFM_ADDR_IN2_SEL) begin
				in_sel_d[1] = WDATA[7:0];
			end else if (ADDR == `PIFM_ADDR_IN3_SEL) begin
				in_sel_d[2] = WDATA[7:0];
			end else if (ADDR == `PIFM_ADDR_IN4_SEL) begin
				in_sel_d[3] = WDATA[7:0];
			end else if (ADDR == `PIFM_ADDR_IN5_SEL) begin
				in_sel_d[4] = WDATA[7:0];
			end else if (ADDR == `PIFM_ADDR_OUT1_SEL) begin
				out_sel_d[0] = WDATA[7:0];
			end else if (ADDR == `PIFM_ADDR_OUT2_SEL) begin
				out_sel_d[1] = WDATA[7:0];
			end else if (ADDR == `PIFM_ADDR_ZS_THRESH) begin
				thresh_d = WDATA[SPEED_W-1:0];
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			in_sel_q[0] <= `PIFM_RST_IN1_SEL;
			in_sel_q[1] <= `PIFM_RST_IN2_SEL;
			in_sel_q[2] <= `PIFM_RST_IN3_SEL;
			in_sel_q[3] <= `PIFM_RST_IN4_SEL;
			in_sel_q[4] <= `PIFM_RST_IN5_SEL;
			out_sel_q[0] <= `PIFM_RST_OUT1_SEL;
			out_sel_q[1] <= `PIFM_RST_OUT2_SEL;
			thresh_q <= SPEED_W'(`PIFM_RST_ZS_THRESH);
		end else begin
			in_sel_q <= in_sel_d;
			out_sel_q <= out_sel_d;
			thresh_q <= thresh_d;
		end
	end

	//--------------------------------------------------------------------------
	// Input function decode
	//--------------------------------------------------------------------------
	logic clear_on;
	logic halt_off;
	logic rev_off;
	logic fwd_off;

	pifm_in_decode #(
		.NUM_IN(NUM_IN)
	) u_in_decode (
		.pin_level(DI_LEVEL),
		.sel(in_sel_q),
		.clear_on(clear_on),
		.halt_off(halt_off),
		.rev_off(rev_off),
		.fwd_off(fwd_off)
	);

	//--------------------------------------------------------------------------
	// Alarm clear edge
	//--------------------------------------------------------------------------
	logic clear_on_q;
	logic clear_on_d;
	logic clear_edge;

	// Only the rising edge clears, so a clear contact held on cannot mask a new alarm.
	assign clear_edge = clear_on && !clear_on_q;

	always_comb begin
		clear_on_d = clear_on;
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			clear_on_q <= 1'b0;
		end else begin
			clear_on_q <= clear_on_d;
		end
	end

	//--------------------------------------------------------------------------
	// Alarm cause latch
	//--------------------------------------------------------------------------
	logic [4:0] cause_q;
	logic [4:0] cause_d;
	logic [4:0] cause_now;

	always_comb begin
		cause_now = 5'h00;
		cause_now[`PIFM_CAUSE_HALT] = halt_off;
		cause_now[`PIFM_CAUSE_REV] = rev_off;
		cause_now[`PIFM_CAUSE_FWD] = fwd_off;
		cause_now[`PIFM_CAUSE_CTRL] = CTRL_CIRCUIT_FAULT;
		cause_now[`PIFM_CAUSE_MOTOR] = MOTOR_POWER_FAULT;
		// A cause still present in the clear cycle stays set.
		cause_d = clear_edge ? cause_now : (cause_q | cause_now);
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			cause_q <= 5'h00;
		end else begin
			cause_q <= cause_d;
		end
	end

	//--------------------------------------------------------------------------
	// Drive state
	//--------------------------------------------------------------------------
	pifm_state_type state_q;
	pifm_state_type state_d;

	always_comb begin
		state_d = state_q;
		case (state_q)
			PIFM_NOPOWER: begin
				if (CONTROL_POWER_OK && cause_d == 5'h00) begin
					state_d = PIFM_READY;
				end else if (CONTROL_POWER_OK) begin
					state_d = PIFM_FAULT;
				end
			end
			PIFM_READY: begin
				if (!CONTROL_POWER_OK) begin
					state_d = PIFM_NOPOWER;
				end else if (cause_d != 5'h00) begin
					state_d = PIFM_FAULT;
				end
			end
			PIFM_FAULT: begin
				if (!CONTROL_POWER_OK) begin
					state_d = PIFM_NOPOWER;
				end else if (cause_d == 5'h00) begin
					state_d = PIFM_READY;
				end
			end
			default: state_d = PIFM_NOPOWER;
		endcase
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state_q <= PIFM_NOPOWER;
		end else begin
			state_q <= state_d;
		end
	end

	//--------------------------------------------------------------------------
	// Output functions
	//--------------------------------------------------------------------------
	logic ready_q;
	logic ready_d;
	logic zero_speed_out_q;
	logic zero_speed_out_d;
	logic fault_q;
	logic fault_d;
	logic [NUM_OUT-1:0] do_q;
	logic [NUM_OUT-1:0] do_d;

	always_comb begin
		ready_d = (state_d == PIFM_READY);
		zero_speed_out_d = (MOTOR_SPEED < thresh_q);
		fault_d = (state_d == PIFM_FAULT);
	end

	genvar k;
	generate
		for (k = 0; k < NUM_OUT; k++) begin : g_out
			pifm_out_select u_out_select (
				.sel(out_sel_q[k]),
				.ready(ready_d),
				.zero_speed(zero_speed_out_d),
				.level(do_d[k])
			);
		end
	endgenerate

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ready_q <= 1'b0;
			zero_speed_out_q <= 1'b0;
			fault_q <= 1'b0;
			do_q <= '0;
		end else begin
			ready_q <= ready_d;
			zero_speed_out_q <= zero_speed_out_d;
			fault_q <= fault_d;
			do_q <= do_d;
		end
	end

	assign DO_LEVEL = do_q;
	assign DRIVE_READY = ready_q;
	assign FAULT_FLAG = fault_q;

	//--------------------------------------------------------------------------
	// Read-only words
	//--------------------------------------------------------------------------
	logic [15:0] status_word;
	logic [15:0] cause_word;
	logic [15:0] pins_word;

	always_comb begin
		status_word = 16'h0000;
		status_word[`PIFM_ST_READY] = ready_q;
		status_word[`PIFM_ST_FAULT] = fault_q;
		status_word[`PIFM_ST_POWER] = CONTROL_POWER_OK;
		status_word[`PIFM_ST_ZSPEED] = zero_speed_out_q;
		cause_word = 16'h0000;
		cause_word[4:0] = cause_q;
		pins_word = 16'h0000;
		pins_word[NUM_IN-1:0] = DI_LEVEL;
		pins_word[8 +: NUM_OUT] = do_q;
	end

	//--------------------------------------------------------------------------
	// Register read port
	//--------------------------------------------------------------------------
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;

	always_comb begin
		rdata_d = 16'h0000;
		if (RD) begin
			if (ADDR == `PIFM_ADDR_IN1_SEL) begin
				rdata_d = {8'h00, in_sel_q[0]};
			end else if (ADDR == `PIFM_ADDR_IN2_SEL) begin
				rdata_d = {8'h00, in_sel_q[1]};
			end else if (ADDR == `PIFM_ADDR_IN3_SEL) begin
				rdata_d = {8'h00, in_sel_q[2]};
			end else if (ADDR == `PIFM_ADDR_IN4_SEL) begin
				rdata_d = {8'h00, in_sel_q[3]};
			end else if (ADDR == `PIFM_ADDR_IN5_SEL) begin
				rdata_d = {8'h00, in_sel_q[4]};
			end else if (ADDR == `PIFM_ADDR_OUT1_SEL) begin
				rdata_d = {8'h00, out_sel_q[0]};
			end else if (ADDR == `PIFM_ADDR_OUT2_SEL) begin
				rdata_d = {8'h00, out_sel_q[1]};
			end else if (ADDR == `PIFM_ADDR_ZS_THRESH) begin
				rdata_d[SPEED_W-1:0] = thresh_q;
			end else if (ADDR == `PIFM_ADDR_STATUS) begin
				rdata_d = status_word;
			end else if (ADDR == `PIFM_ADDR_CAUSE) begin
				rdata_d = cause_word;
			end else if (ADDR == `PIFM_ADDR_PINS) begin
				rdata_d = pins_word;
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rdata_q <= 16'h0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign RDATA = rdata_q;

endmodule : pifm_top
